// [design/wdtgc_top.v]
// guarded watchdog timer with an axi4-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "wdtgc_consts.vh"

// Notes on behaviour
// (RULE1) counter advances only on ticks of the separate 1 MHz watchdog oscillator.
// (RULE2) the restart instruction clears the counter to zero.
// (RULE3) counter also clears while disabled and on any chip reset.
// (RULE4) an expired timeout without restart resets the device.
// (RULE5) timeout is 16384 oscillator cycles shifted left by the 3-bit select.
// (RULE6) control bits 7 to 5 always read as zero.
// (RULE7) a written change enable clears itself four clock cycles later.
// (RULE8) writing enable one enables; writing zero disables when guarded.
// (RULE9) enable only clears while change enable reads one.
// (RULE10) software sets change enable and enable together, then clears enable within four.
// (RULE11) the prescaler select changes only while change enable is set.
// (RULE12) with the safety fuse clear the watchdog starts disabled, freely enabled.
// (RULE13) with the safety fuse set it stays enabled and enable reads one.
// (RULE14) a timeout gives a one-cycle reset pulse.
// (RULE15) a timeout sets the reset flag; power-on reset or writing zero clears it.
// (RULE16) oscillator ticks cross into the cpu clock domain through synchronisers.
// (RULE17) a 21-bit counter supplies the eight selectable timeout lengths.
module wdtgc_top #(
  parameter CNT_W = 21
) (
  // clock, reset and watchdog pins
  input wire aclk,
  input wire aresetn,
  input wire wdt_osc_clk,
  input wire watchdog_restart_instr,
  input wire safety_level_fuse,
  output reg wdt_reset_pulse,
  output reg irq,
  // axi4-lite register slave
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ============================================================
  // helpers
  function [CNT_W-1:0] tmo_last;
    input [2:0] sel;
    reg [31:0] t;
    begin
      // the 32-bit intermediate holds the longest count before it is cut
      t = ({10'h000, `WDTGC_BASE_CYCLES} << sel) - 32'h0000_0001;
      tmo_last = t[CNT_W-1:0];
    end
  endfunction

  // the two low address bits are ignored: every register is one aligned word
  function [7:0] word_addr;
    input [7:0] a;
    begin
      word_addr = {a[7:2], 2'b00};
    end
  endfunction

  // ============================================================
  // reset image of the control register
  localparam [7:0] CTRL_RST = `WDTGC_CTRL_RESET;
  localparam [0:0] EN_RST = CTRL_RST[`WDTGC_CTRL_EN];
  localparam [2:0] PSEL_RST = CTRL_RST[`WDTGC_CTRL_PSEL_MSB:`WDTGC_CTRL_PSEL_LSB];

  // ============================================================
  // state
  // two flops settle the sampled oscillator, the third finds its rising edge
  reg osc_s1_q;
  reg osc_s2_q;
  reg osc_s3_q;
  reg [CNT_W-1:0] wdt_cnt_q;
  reg [2:0] ce_cnt_q;
  reg en_q;
  reg [2:0] psel_q;
  reg rst_flag_q;
  reg irq_stat_q;
  reg irq_mask_q;
  reg [7:0] aw_addr_q;
  reg aw_have_q;
  reg [7:0] w_data_q;
  reg w_strb0_q;
  reg w_have_q;

  wire osc_tick;
  wire ce_open;
  wire en_eff;
  wire cnt_at_last;
  wire tmo_hit;
  wire wr_fire;
  wire wr_ok;
  wire wr_ctrl;
  wire wr_rst;
  wire wr_istat;
  wire wr_imask;
  wire wr_mapped;
  wire [7:0] ar_word;

  // ============================================================
  // decoded strobes
  assign osc_tick = osc_s2_q & ~osc_s3_q; // see RULE16
  assign ce_open = (ce_cnt_q != 3'h0);
  // the fuse overrides the enable bit without changing it, so clearing the
  // fuse brings back whatever software last wrote
  assign en_eff = en_q | safety_level_fuse; // see RULE13
  assign cnt_at_last = (wdt_cnt_q == tmo_last(psel_q)); // see RULE5
  // a restart in the cycle of the last tick wins over the timeout
  assign tmo_hit = en_eff & ~watchdog_restart_instr & osc_tick & cnt_at_last;
  // one write at a time: the next pair waits until the response is taken
  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_ok = wr_fire & w_strb0_q;
  assign wr_ctrl = wr_ok & (aw_addr_q == `WDTGC_OFF_CTRL);
  assign wr_rst = wr_ok & (aw_addr_q == `WDTGC_OFF_RST_STATUS);
  assign wr_istat = wr_ok & (aw_addr_q == `WDTGC_OFF_IRQ_STATUS);
  assign wr_imask = wr_ok & (aw_addr_q == `WDTGC_OFF_IRQ_MASK);
  assign wr_mapped = (aw_addr_q == `WDTGC_OFF_CTRL) || (aw_addr_q == `WDTGC_OFF_RST_STATUS) ||
                     (aw_addr_q == `WDTGC_OFF_IRQ_STATUS) || (aw_addr_q == `WDTGC_OFF_IRQ_MASK);
  assign ar_word = word_addr(s_axi_araddr);

  // ============================================================
  // oscillator crossing and timeout counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      wdt_cnt_q <= {CNT_W{1'b0}}; // see RULE3
      wdt_reset_pulse <= 1'b0;
    end else begin
      // the oscillator is far slower than aclk, so every tick is seen
      // limitation: each oscillator level must last two aclk cycles or ticks are lost
      osc_s1_q <= wdt_osc_clk; // see RULE1
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      wdt_reset_pulse <= tmo_hit; // see RULE14
      // disable and restart come first so that a stale count never fires late
      if (!en_eff) begin
        wdt_cnt_q <= {CNT_W{1'b0}}; // see RULE3
      end else if (watchdog_restart_instr) begin
        wdt_cnt_q <= {CNT_W{1'b0}}; // see RULE2
      end else if (tmo_hit) begin
        wdt_cnt_q <= {CNT_W{1'b0}}; // see RULE4
      end else if (osc_tick) begin
        wdt_cnt_q <= wdt_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // see RULE17
      end
    end
  end

  // ============================================================
  // guarded control register
  always @(posedge aclk) begin
    if (!aresetn) begin
      ce_cnt_q <= 3'h0;
      en_q <= EN_RST; // see RULE12
      psel_q <= PSEL_RST;
    end else begin
      // only change enable written together with enable opens the window
      if (wr_ctrl && w_data_q[`WDTGC_CTRL_CE] && w_data_q[`WDTGC_CTRL_EN]) begin
        ce_cnt_q <= `WDTGC_CE_CYCLES; // see RULE10
      end else if (ce_open) begin
        ce_cnt_q <= ce_cnt_q - 3'h1; // see RULE7
      end
      if (wr_ctrl) begin
        if (w_data_q[`WDTGC_CTRL_EN]) begin
          en_q <= 1'b1; // see RULE8
        end else if (ce_open) begin
          en_q <= 1'b0; // see RULE9
        end
        // the opening write leaves the prescaler alone; the next write sets it
        if (ce_open) begin
          psel_q <= w_data_q[`WDTGC_CTRL_PSEL_MSB:`WDTGC_CTRL_PSEL_LSB]; // see RULE11
        end
      end
    end
  end

  // ============================================================
  // reset flag and interrupt; a timeout beats a clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      rst_flag_q <= 1'b0;
      irq_stat_q <= 1'b0;
      irq_mask_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      // the pulse only asks for a reset; the flag survives until aresetn or software
      if (tmo_hit) begin
        rst_flag_q <= 1'b1; // see RULE15
      end else if (wr_rst && !w_data_q[`WDTGC_RST_FLAG_BIT]) begin
        rst_flag_q <= 1'b0; // see RULE15
      end
      if (tmo_hit) begin
        irq_stat_q <= 1'b1;
      end else if (wr_istat && w_data_q[`WDTGC_IRQ_TMO_BIT]) begin
        irq_stat_q <= 1'b0;
      end
      if (wr_imask) begin
        irq_mask_q <= w_data_q[`WDTGC_IRQ_TMO_BIT];
      end
      // registered, so irq trails the status and mask bits by one cycle
      irq <= irq_stat_q & irq_mask_q;
    end
  end

  // ============================================================
  // axi4-lite write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= 8'h00;
      aw_have_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb0_q <= 1'b0;
      w_have_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDTGC_RESP_OKAY;
    end else begin
      // ready drops after a handshake so that one item is never taken twice
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= word_addr(s_axi_awaddr);
        aw_have_q <= 1'b1;
      end
      // only byte 0 matters: every register lives in the low eight bits
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
        w_have_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `WDTGC_RESP_OKAY : `WDTGC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // axi4-lite read path
  reg [31:0] rd_word;
  reg rd_hit;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ar_word == `WDTGC_OFF_CTRL) begin
      // top three bits stay zero; see RULE6
      rd_word[`WDTGC_CTRL_CE] = ce_open;
      rd_word[`WDTGC_CTRL_EN] = en_eff; // see RULE13
      rd_word[`WDTGC_CTRL_PSEL_MSB:`WDTGC_CTRL_PSEL_LSB] = psel_q;
    end else if (ar_word == `WDTGC_OFF_RST_STATUS) begin
      rd_word[`WDTGC_RST_FLAG_BIT] = rst_flag_q;
    end else if (ar_word == `WDTGC_OFF_IRQ_STATUS) begin
      rd_word[`WDTGC_IRQ_TMO_BIT] = irq_stat_q;
    end else if (ar_word == `WDTGC_OFF_IRQ_MASK) begin
      rd_word[`WDTGC_IRQ_TMO_BIT] = irq_mask_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ============================================================
  // read answer register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `WDTGC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      // the word is captured at the address handshake and held until taken
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? `WDTGC_RESP_OKAY : `WDTGC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // wdtgc_top
`default_nettype wire

// [design/wdtgc_consts.vh]
// constants for the guarded watchdog timer: offsets, fields, resets and timing
`ifndef WDTGC_CONSTS_VH
`define WDTGC_CONSTS_VH

// ============================================================
// register byte offsets
`define WDTGC_OFF_CTRL 8'h00
`define WDTGC_OFF_RST_STATUS 8'h04
`define WDTGC_OFF_IRQ_STATUS 8'h08
`define WDTGC_OFF_IRQ_MASK 8'h0C

// ============================================================
// watchdog_control fields
`define WDTGC_CTRL_CE 4
`define WDTGC_CTRL_EN 3
`define WDTGC_CTRL_PSEL_MSB 2
`define WDTGC_CTRL_PSEL_LSB 0
`define WDTGC_CTRL_RESET 8'h00

// reset_status_register and interrupt status / mask fields
`define WDTGC_RST_FLAG_BIT 0
`define WDTGC_IRQ_TMO_BIT 0

// ============================================================
// timing
`define WDTGC_OSC_HZ 32'h000F_4240
`define WDTGC_CE_CYCLES 3'h4
`define WDTGC_BASE_CYCLES 22'h00_4000

// ============================================================
// bus answers
`define WDTGC_RESP_OKAY 2'h0
`define WDTGC_RESP_SLVERR 2'h2

`endif

// [verification/wdtgc_props.sv]
// assertions on the guarded watchdog ports
`timescale 1ns/1ns
`default_nettype none
module wdtgc_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic watchdog_restart_instr,
  input wire logic wdt_reset_pulse,
  input wire logic irq,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========
  // read steps
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence ctrl_ans;
    s_axi_rvalid && s_axi_rresp == 2'h0 && s_axi_rdata[7:5] == 3'h0;
  endsequence
  AST_PULSE_ONE: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
    else $error("reset pulse too long");
  AST_RESTART: assert property (watchdog_restart_instr |=> !wdt_reset_pulse [*2])
    else $error("timeout right after restart");
  AST_CTRL_RSV: assert property ((s_axi_araddr[7:2] == 6'h00) ##0 ar_take |=> ctrl_ans)
    else $error("control read bad");
  AST_BAD_RD: assert property ((s_axi_araddr[7:4] != 4'h0) ##0 ar_take |=>
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_AR_STALL: assert property (ar_take |=> !s_axi_arready)
    else $error("address taken back to back");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(s_axi_bvalid))
    else $error("irq fell without a write");
endmodule // wdtgc_props
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench of the guarded watchdog
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic aclk = 0, aresetn = 0, wdt_osc_clk = 0, watchdog_restart_instr = 0, safety_level_fuse = 0;
  logic wdt_reset_pulse, irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d, s_axi_wdata = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  int failures = 0, n_tests = 0, cyc = 0, ticks = 0, m_en = 0, m_ps = 0, m_open = 0;
  logic [8:0] tbl [9] = '{9'h108, 9'h100, 9'h10b, 9'h018, 9'h10d, 9'h018, 9'h100, 9'h108, 9'h118};
  wdtgc_top i_dut (.aclk, .aresetn, .wdt_osc_clk, .watchdog_restart_instr, .safety_level_fuse,
    .wdt_reset_pulse, .irq, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial forever #50 aclk = ~aclk;
  // oscillator at a quarter of aclk, the fastest the sampler tolerates
  always @(posedge aclk) begin
    cyc++;
    if (cyc % 2 == 0) begin
      wdt_osc_clk <= ~wdt_osc_clk;
      if (!wdt_osc_clk) ticks++;
    end
    if (cyc == 90000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'($urandom), v};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, input bit late = 1'b0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= !late;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // the model assumes a write right after an opening write still lands inside the window
  task automatic wrc(input logic [4:0] v);
    wr(8'h00, {3'($urandom), v});
    if (v[4] && v[3]) begin
      m_en = 1;
      m_open = 1;
    end else begin
      if (v[3]) m_en = 1;
      else if (m_open) m_en = 0;
      if (m_open) m_ps = v[2:0];
      m_open = 0;
    end
  endtask
  task automatic rc(input string nm);
    rd(8'h00);
    chk(nm, {r, d}, {29'h0, 1'(m_open), 1'(m_en | safety_level_fuse), 3'(m_ps)});
    m_open = 0;
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'ha6d0));
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rc("ctrl_reset");
    foreach (tbl[i]) begin
      wrc(tbl[i][4:0]);
      if (tbl[i][8]) rc("ctrl_seq");
    end
    repeat (6) @(posedge aclk);
    rc("ce_clear");
    rd(8'h10, 1'b1);
    chk("bad_rd", {r, d}, {2'h2, 32'h0000_0000});
    wr(8'h14, 8'hff);
    chk("bad_wr", 34'(r), 34'h2);
    wr(8'h0c, 8'h01);
    watchdog_restart_instr <= 1;
    @(posedge aclk);
    watchdog_restart_instr <= 0;
    ticks = 0;
    while (!wdt_reset_pulse) @(posedge aclk);
    chk("ticks", 34'(ticks >= 16382 && ticks <= 16386), 34'h1);
    @(posedge aclk);
    chk("pulse", 34'(wdt_reset_pulse), 34'h0);
    rd(8'h04);
    chk("flag", {r, d}, 34'h1);
    chk("irq_set", 34'(irq), 34'h1);
    wr(8'h04, 8'h00);
    rd(8'h04);
    chk("flag_clr", {r, d}, 34'h0);
    wr(8'h08, 8'h01);
    repeat (2) @(posedge aclk);
    chk("irq_clr", 34'(irq), 34'h0);
    safety_level_fuse <= 1;
    wrc(5'h18);
    wrc(5'h02);
    rc("ctrl_fused");
    stop_test();
  end
endmodule // tb_top
bind wdtgc_top wdtgc_props i_props (.aclk, .aresetn, .watchdog_restart_instr, .wdt_reset_pulse,
  .irq, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire
